// *** hltm_defs.svh ***
`ifndef HLTM_DEFS_SVH
`define HLTM_DEFS_SVH

// Mode codes
`define HLTM_MODE_SW_GATE 5'h00
`define HLTM_MODE_HW_GATE_HI 5'h01
`define HLTM_MODE_HW_GATE_LO 5'h02
`define HLTM_MODE_ER_ANY 5'h03
`define HLTM_MODE_ER_RISE 5'h04
`define HLTM_MODE_ER_FALL 5'h05
`define HLTM_MODE_LR_LOW 5'h06
`define HLTM_MODE_LR_HIGH 5'h07
`define HLTM_MODE_OS_SW 5'h08
`define HLTM_MODE_OS_RISE 5'h09
`define HLTM_MODE_OS_FALL 5'h0a
`define HLTM_MODE_OS_ANY 5'h0b
`define HLTM_MODE_OS_RISE_RR 5'h0c
`define HLTM_MODE_OS_FALL_FR 5'h0d
`define HLTM_MODE_OS_RISE_LR 5'h0e
`define HLTM_MODE_OS_FALL_HR 5'h0f
`define HLTM_MODE_MS_RISE 5'h11
`define HLTM_MODE_MS_FALL 5'h12
`define HLTM_MODE_MS_ANY 5'h13
`define HLTM_MODE_LS_HIGH 5'h16
`define HLTM_MODE_LS_LOW 5'h17
// Reset values
`define HLTM_COUNT_RST 8'h00
`define HLTM_PERIOD_RST 8'hff
// Synchronizer depth for pin inputs
`define HLTM_SYNC_STAGES 3
`endif

// *** hltm_edge.sv ***
`timescale 1ns/10ps
// Edge detect on the timer tick: compares with the sample of the previous tick
module hltm_edge (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Sampling
  input wire logic i_tick,
  input wire logic i_level,
  output logic o_rise,
  output logic o_fall
);
  logic prev_q;

  // Previous tick sample
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_q <= 1'b0;
    end else if (i_tick) begin
      prev_q <= i_level;
    end
  end

  // Edges are only meaningful together with i_tick
  assign o_rise = i_level & ~prev_q;
  assign o_fall = ~i_level & prev_q;
endmodule

// *** hltm_mode_ctrl.sv ***
`timescale 1ns/10ps
`include "hltm_defs.svh"
// Mode controller for the 8-bit period timer with hardware limit
module hltm_mode_ctrl
  import hltm_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Software controls
  input wire logic i_on_set,
  input wire logic i_on_clr,
  input wire logic [4:0] i_mode,
  input wire logic [WIDTH-1:0] i_period_value,
  input wire logic i_debug,
  // Prescaled timer tick
  input wire logic i_tick,
  // External reset/trigger pin
  input wire logic i_ext_reset_signal,
  // Status
  output logic o_on,
  output logic [WIDTH-1:0] o_count_value,
  output logic o_match,
  output logic o_running
);
  // Elaboration check on the counter width
  if (WIDTH < 2 || WIDTH > 16) begin
    $error("hltm_mode_ctrl: WIDTH out of range");
  end

  logic on_q;
  logic on_sync_q;
  logic [WIDTH-1:0] cnt_q;
  logic match_q;
  logic run_q;
  hltm_state_t state_q;
  logic ers_sync;
  logic ers;
  logic rise;
  logic fall;
  logic edge_rise;
  logic edge_fall;
  logic lvl_q1;
  logic lvl_q2;
  logic at_match;

  // External signal through the pin synchronizer
  hltm_sync #(.RST_VAL(0)) u_sync (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_async(i_ext_reset_signal),
    .o_sync(ers_sync)
  );

  // Debug mode: levels read as a quiet low and edges are dropped, so entering debug fakes no edge
  assign ers = ers_sync & ~i_debug;

  // Detector tracks the unmasked line, so leaving debug fires no stale edge either
  hltm_edge u_edge (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_tick(i_tick),
    .i_level(ers_sync),
    .o_rise(edge_rise),
    .o_fall(edge_fall)
  );
  assign rise = edge_rise & ~i_debug;
  assign fall = edge_fall & ~i_debug;

  assign at_match = (cnt_q == i_period_value);

  // Decoded mode attributes
  logic m_gate;
  logic gate_ok;
  logic m_eres;
  logic eres_hit;
  logic m_lres;
  logic lres_lvl;
  logic m_estart;
  logic estart_hit;
  logic m_osclr;
  logic m_mono;
  logic m_lstart;
  logic m_sw;
  logic m_rsvd;

  always_comb begin
    m_gate = 1'b0;
    gate_ok = 1'b1;
    m_eres = 1'b0;
    eres_hit = 1'b0;
    m_lres = 1'b0;
    lres_lvl = 1'b0;
    m_estart = 1'b0;
    estart_hit = 1'b0;
    m_osclr = 1'b0;
    m_mono = 1'b0;
    m_lstart = 1'b0;
    m_sw = 1'b0;
    m_rsvd = 1'b0;
    case (i_mode)
      `HLTM_MODE_SW_GATE: m_sw = 1'b1;
      `HLTM_MODE_HW_GATE_HI: begin
        m_sw = 1'b1;
        m_gate = 1'b1;
        gate_ok = ers;
      end
      `HLTM_MODE_HW_GATE_LO: begin
        m_sw = 1'b1;
        m_gate = 1'b1;
        gate_ok = ~ers;
      end
      `HLTM_MODE_ER_ANY: begin
        m_sw = 1'b1;
        m_eres = 1'b1;
        eres_hit = rise | fall;
      end
      `HLTM_MODE_ER_RISE: begin
        m_sw = 1'b1;
        m_eres = 1'b1;
        eres_hit = rise;
      end
      `HLTM_MODE_ER_FALL: begin
        m_sw = 1'b1;
        m_eres = 1'b1;
        eres_hit = fall;
      end
      `HLTM_MODE_LR_LOW: begin
        m_sw = 1'b1;
        m_lres = 1'b1;
        lres_lvl = ~ers;
      end
      `HLTM_MODE_LR_HIGH: begin
        m_sw = 1'b1;
        m_lres = 1'b1;
        lres_lvl = ers;
      end
      `HLTM_MODE_OS_SW: begin
        m_sw = 1'b1;
        m_osclr = 1'b1;
      end
      `HLTM_MODE_OS_RISE, `HLTM_MODE_MS_RISE: begin
        m_estart = 1'b1;
        estart_hit = rise;
        m_osclr = ~i_mode[4];
        m_mono = i_mode[4];
      end
      `HLTM_MODE_OS_FALL, `HLTM_MODE_MS_FALL: begin
        m_estart = 1'b1;
        estart_hit = fall;
        m_osclr = ~i_mode[4];
        m_mono = i_mode[4];
      end
      `HLTM_MODE_OS_ANY, `HLTM_MODE_MS_ANY: begin
        m_estart = 1'b1;
        estart_hit = rise | fall;
        m_osclr = ~i_mode[4];
        m_mono = i_mode[4];
      end
      `HLTM_MODE_OS_RISE_RR: begin
        m_estart = 1'b1;
        estart_hit = rise;
        m_eres = 1'b1;
        eres_hit = rise;
        m_osclr = 1'b1;
      end
      `HLTM_MODE_OS_FALL_FR: begin
        m_estart = 1'b1;
        estart_hit = fall;
        m_eres = 1'b1;
        eres_hit = fall;
        m_osclr = 1'b1;
      end
      `HLTM_MODE_OS_RISE_LR: begin
        m_estart = 1'b1;
        estart_hit = rise;
        m_lres = 1'b1;
        lres_lvl = ~ers;
        m_osclr = 1'b1;
      end
      `HLTM_MODE_OS_FALL_HR: begin
        m_estart = 1'b1;
        estart_hit = fall;
        m_lres = 1'b1;
        lres_lvl = ers;
        m_osclr = 1'b1;
      end
      `HLTM_MODE_LS_HIGH: begin
        m_lstart = 1'b1;
        m_lres = 1'b1;
        lres_lvl = ~ers;
        m_osclr = 1'b1;
      end
      `HLTM_MODE_LS_LOW: begin
        m_lstart = 1'b1;
        m_lres = 1'b1;
        lres_lvl = ers;
        m_osclr = 1'b1;
      end
      default: m_rsvd = 1'b1;
    endcase
  end

  // Enable bit: software set/clear; hardware clear on one-shot match.
  // A software set in the same cycle as the hardware clear wins.
  logic hw_clr;
  assign hw_clr = i_tick & run_q & at_match & m_osclr & on_sync_q;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      on_q <= 1'b0;
    end else if (i_on_set) begin
      on_q <= 1'b1;
    end else if (i_on_clr || hw_clr) begin
      on_q <= 1'b0;
    end
  end

  // Enable seen by the timer one clock later; the pin path through the synchronizer takes four clocks
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      on_sync_q <= 1'b0;
    end else begin
      on_sync_q <= on_q & ~hw_clr;
    end
  end

  // Level reset qualified two ticks; ignored when enable is clear
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lvl_q1 <= 1'b0;
      lvl_q2 <= 1'b0;
    end else if (!on_sync_q || !m_lres) begin
      lvl_q1 <= 1'b0;
      lvl_q2 <= 1'b0;
    end else if (i_tick) begin
      lvl_q1 <= lres_lvl;
      lvl_q2 <= lvl_q1 & lres_lvl;
    end
  end

  // Start state: edge-start modes arm on enable and wait for an edge
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= HLTM_ST_IDLE;
    end else if (!on_sync_q || m_rsvd) begin
      state_q <= HLTM_ST_IDLE;
    end else if (i_tick) begin
      unique case (state_q)
        HLTM_ST_IDLE: begin
          if (m_estart) begin
            state_q <= HLTM_ST_ARMED;
          end else if (m_sw || (m_lstart && !lres_lvl)) begin
            state_q <= HLTM_ST_RUN;
          end
        end
        HLTM_ST_ARMED: begin
          if (estart_hit) begin
            state_q <= HLTM_ST_RUN;
          end
        end
        HLTM_ST_RUN: begin
          if (at_match && (m_osclr || m_mono)) begin
            state_q <= m_estart ? HLTM_ST_ARMED : HLTM_ST_IDLE;
          end
        end
        default: state_q <= HLTM_ST_IDLE;
      endcase
    end
  end

  assign run_q = (state_q == HLTM_ST_RUN);

  // Counter steps on the tick; resets take priority over counting
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= WIDTH'(`HLTM_COUNT_RST);
    end else if (m_rsvd) begin
      cnt_q <= WIDTH'(`HLTM_COUNT_RST);
    end else if (i_tick) begin
      if (lvl_q2 && lres_lvl) begin
        cnt_q <= '0;
      end else if (run_q && m_eres && eres_hit) begin
        cnt_q <= '0;
      end else if (run_q && on_sync_q && gate_ok) begin
        if (at_match) begin
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  // Match pulse, one clock wide on the tick after equality
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      match_q <= 1'b0;
    end else begin
      match_q <= i_tick & run_q & on_sync_q & gate_ok & at_match;
    end
  end

  // Registered status outputs
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_running <= 1'b0;
    end else begin
      o_running <= run_q & on_sync_q & gate_ok & ~lvl_q2;
    end
  end

  assign o_on = on_q;
  assign o_count_value = cnt_q;
  assign o_match = match_q;

  // Assertions
  property p_gate_hold;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_tick && m_gate && !gate_ok && !lvl_q2 && !m_rsvd) |=> $stable(cnt_q);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gated counter moved");

  property p_wrap;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_tick && run_q && on_sync_q && gate_ok && at_match && !m_rsvd) |=> (cnt_q == '0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not clear after match");

  property p_os_clear;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (hw_clr && !i_on_set) |=> !on_q;
  endproperty
  a_os_clear: assert property (p_os_clear) else $error("enable not cleared on one-shot match");

  property p_mono_keep;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (m_mono && on_q && !i_on_clr) |=> on_q;
  endproperty
  a_mono_keep: assert property (p_mono_keep) else $error("monostable dropped enable");

  property p_rsvd_idle;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      m_rsvd |=> (cnt_q == '0);
  endproperty
  a_rsvd_idle: assert property (p_rsvd_idle) else $error("reserved mode not idle");

  property p_eres;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_tick && run_q && m_eres && eres_hit && !m_rsvd) |=> (cnt_q == '0);
  endproperty
  a_eres: assert property (p_eres) else $error("edge reset missed");

  property p_lvl_ignore;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      !on_sync_q |=> !lvl_q2;
  endproperty
  a_lvl_ignore: assert property (p_lvl_ignore) else $error("level reset while disabled");

  property p_armed_wait;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (state_q == HLTM_ST_ARMED && i_tick && !estart_hit && on_sync_q && !m_rsvd) |=> !run_q;
  endproperty
  a_armed_wait: assert property (p_armed_wait) else $error("started without edge");
endmodule

// *** hltm_pkg.sv ***
package hltm_pkg;
  // Start/reset behaviour family derived from the mode code
  typedef enum logic [2:0] {
    HLTM_CLS_FREE = 3'h0,
    HLTM_CLS_ONESHOT = 3'h1,
    HLTM_CLS_MONO = 3'h2,
    HLTM_CLS_RSVD = 3'h3
  } hltm_class_t;
  // Run state of the counter
  typedef enum logic [2:0] {
    HLTM_ST_IDLE = 3'b001,
    HLTM_ST_ARMED = 3'b010,
    HLTM_ST_RUN = 3'b100
  } hltm_state_t;
endpackage

// *** hltm_sync.sv ***
`timescale 1ns/10ps
`include "hltm_defs.svh"
// Three-stage synchronizer; output moves only when stages two and three agree
module hltm_sync
  import hltm_pkg::*;
#(
  parameter int RST_VAL = 0
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Data
  input wire logic i_async,
  output logic o_sync
);
  logic [`HLTM_SYNC_STAGES-1:0] stage_q;

  // Reset level is a single bit; anything else cannot be served
  if (RST_VAL != 0 && RST_VAL != 1) begin
    $error("hltm_sync: RST_VAL must be 0 or 1");
  end

  // Shift chain; the first stage feeds only the second
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stage_q <= {`HLTM_SYNC_STAGES{1'(RST_VAL)}};
    end else begin
      stage_q <= {stage_q[`HLTM_SYNC_STAGES-2:0], i_async};
    end
  end

  // Filtered value updates once the last two stages match
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sync <= 1'(RST_VAL);
    end else if (stage_q[2] == stage_q[1]) begin
      o_sync <= stage_q[2];
    end
  end
endmodule

// *** hltm_trig_src.sv ***
`timescale 1ns/10ps
// External trigger source; never moves its line faster than the timer can follow
module hltm_trig_src (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Level asked for by the bench
  input wire logic i_level_req,
  // Trigger line
  output logic o_ext_reset_signal
);
  logic [2:0] gap_q;
  // Each level stands six clocks, so edges stay spaced and levels long enough
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gap_q <= 3'h0;
      o_ext_reset_signal <= 1'b0;
    end else if (gap_q != 3'h0) begin
      gap_q <= gap_q - 3'h1;
    end else if (i_level_req != o_ext_reset_signal) begin
      o_ext_reset_signal <= i_level_req;
      gap_q <= 3'h5;
    end
  end
endmodule

// *** tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  logic clk, arst_n, on_set, on_clr, debug, tick, ext_req, ext, on, match, running, lvl;
  logic [4:0] mode;
  logic [7:0] period, count, c;
  int failures = 0;
  int num_checks = 0;

  hltm_trig_src src (.i_core_clk(clk), .i_arst_n(arst_n), .i_level_req(ext_req), .o_ext_reset_signal(ext));
  hltm_mode_ctrl #(.WIDTH(8)) dut (
    .i_core_clk(clk), .i_arst_n(arst_n), .i_on_set(on_set), .i_on_clr(on_clr), .i_mode(mode),
    .i_period_value(period), .i_debug(debug), .i_tick(tick), .i_ext_reset_signal(ext),
    .o_on(on), .o_count_value(count), .o_match(match), .o_running(running)
  );

  // Free-running 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Inputs always move 5 ns after the rising edge, away from sampling
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic stop_test();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for a count value, then judge it
  task automatic wait_cnt(input logic [7:0] exp, input int max);
    int i;
    i = 0;
    while (count !== exp && i < max) begin
      step(1);
      i++;
    end
    chk(count, exp);
  endtask

  task automatic pulse_on(input logic set);
    if (set) on_set = 1'b1;
    else on_clr = 1'b1;
    step(1);
    on_set = 1'b0;
    on_clr = 1'b0;
  endtask

  // Fresh reset, line settled at l well before the enable is set
  task automatic start(input logic [4:0] m, input logic [7:0] p, input logic l);
    arst_n = 1'b0;
    ext_req = l;
    mode = m;
    period = p;
    step(2);
    arst_n = 1'b1;
    step(10);
    pulse_on(1'b1);
  endtask

  task automatic t_sw_gate();
    start(5'h00, 8'h03, 1'b0);
    step(1);
    chk(count, 8'h00);
    wait_cnt(8'h03, 12);
    chk({7'h0, running}, 8'h01);
    step(1);
    chk(count, 8'h00);
    chk({7'h0, match}, 8'h01);
    tick = 1'b0;
    step(5);
    chk(count, 8'h00);
    tick = 1'b1;
    pulse_on(1'b0);
    step(6);
    c = count;
    step(4);
    chk(count, c);
  endtask

  task automatic t_gates();
    for (int i = 0; i < 2; i++) begin
      start(5'(1 + i), 8'hff, 1'(i));
      step(10);
      chk(count, 8'h00);
      chk({7'h0, running}, 8'h00);
      ext_req = ~ext_req;
      wait_cnt(8'h05, 20);
    end
    debug = 1'b1;
    start(5'h01, 8'hff, 1'b1);
    step(12);
    chk(count, 8'h00);
    debug = 1'b0;
    step(12);
    chk({7'h0, count != 8'h00}, 8'h01);
  endtask

  task automatic t_edge_reset();
    for (int m = 3; m <= 5; m++) begin
      start(5'(m), 8'hff, m == 5);
      wait_cnt(8'h14, 40);
      ext_req = ~ext_req;
      wait_cnt(8'h02, 12);
      wait_cnt(8'h14, 40);
      ext_req = ~ext_req;
      step(8);
      chk({7'h0, count > 8'h14}, {7'h0, m != 3});
    end
  endtask

  task automatic t_level_reset();
    for (int m = 6; m <= 7; m++) begin
      lvl = (m == 7);
      start(5'(m), 8'hff, ~lvl);
      wait_cnt(8'h0a, 30);
      ext_req = lvl;
      step(8);
      chk(count, 8'h00);
      chk({7'h0, running}, 8'h00);
      step(4);
      chk(count, 8'h00);
      ext_req = ~lvl;
      wait_cnt(8'h03, 14);
    end
  endtask

  task automatic t_oneshot_sw();
    start(5'h08, 8'h06, 1'b0);
    wait_cnt(8'h03, 12);
    pulse_on(1'b0);
    step(6);
    c = count;
    step(4);
    chk(count, c);
    pulse_on(1'b1);
    wait_cnt(c + 8'h01, 5);
    wait_cnt(8'h06, 10);
    step(2);
    chk({7'h0, on}, 8'h00);
    step(10);
    chk(count, 8'h00);
  endtask

  // Edge-started one-shots, with mid-cycle resets for the hardware limit kinds
  task automatic t_oneshot_edge();
    for (int m = 9; m <= 15; m++) begin
      lvl = (m == 10 || m == 13 || m == 15);
      start(5'(m), 8'h20, lvl);
      step(10);
      chk(count, 8'h00);
      ext_req = ~lvl;
      wait_cnt(8'h0c, 20);
      if (m >= 12) begin
        ext_req = lvl;
        step(8);
        if (m >= 14) chk(count, 8'h00);
        ext_req = ~lvl;
        step(8);
        chk({7'h0, count < 8'h0a}, 8'h01);
      end
      wait_cnt(8'h20, 40);
      step(2);
      chk({7'h0, on}, 8'h00);
      pulse_on(1'b1);
      step(10);
      chk(count, 8'h00);
    end
  endtask

  task automatic t_mono();
    for (int m = 17; m <= 19; m++) begin
      lvl = (m == 18);
      start(5'(m), 8'h08, lvl);
      step(10);
      chk(count, 8'h00);
      ext_req = ~lvl;
      wait_cnt(8'h08, 20);
      step(2);
      chk({7'h0, on}, 8'h01);
      chk(count, 8'h00);
      chk({7'h0, running}, 8'h00);
      ext_req = lvl;
      step(8);
      ext_req = ~lvl;
      wait_cnt(8'h05, 20);
    end
  endtask

  // Level-start one-shots: enabled at the reset level, then started and held by the line, finished by the period match
  task automatic t_level_start();
    for (int m = 22; m <= 23; m++) begin
      lvl = (m == 23);
      start(5'(m), 8'h10, lvl);
      step(10);
      chk(count, 8'h00);
      ext_req = ~lvl;
      wait_cnt(8'h05, 14);
      chk({7'h0, running}, 8'h01);
      ext_req = lvl;
      step(10);
      chk(count, 8'h00);
      chk({7'h0, running}, 8'h00);
      ext_req = ~lvl;
      wait_cnt(8'h10, 30);
      step(2);
      chk({7'h0, on}, 8'h00);
    end
  endtask

  task automatic t_reserved();
    logic [4:0] rsvd [4];
    rsvd = '{5'h10, 5'h14, 5'h15, 5'h18};
    foreach (rsvd[i]) begin
      start(rsvd[i], 8'h04, 1'b0);
      ext_req = 1'b1;
      step(8);
      ext_req = 1'b0;
      step(8);
      chk(count, 8'h00);
    end
  endtask

  // Hang guard, far beyond the under two thousand cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test();
  end

  initial begin
    arst_n = 1'b0;
    on_set = 1'b0;
    on_clr = 1'b0;
    debug = 1'b0;
    tick = 1'b1;
    ext_req = 1'b0;
    mode = 5'h00;
    period = 8'hff;
    step(8);
    t_sw_gate();
    t_gates();
    t_edge_reset();
    t_level_reset();
    t_oneshot_sw();
    t_oneshot_edge();
    t_mono();
    t_level_start();
    t_reserved();
    stop_test();
  end
endmodule
